// ### logic/rtc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the user application and the top-level logic
interface rtc_link_if;
  // ----------------------------------------------------------------
  // gpio override
  // ----------------------------------------------------------------
  logic [rtc_pkg::GPIO_W-1:0] ovr_mask; // bit taken by user
  logic [rtc_pkg::GPIO_W-1:0] flt_mask; // bit floated
  logic [rtc_pkg::GPIO_W-1:0] drv_val; // value to drive
  logic [rtc_pkg::GPIO_W-1:0] rbk_bus; // pin level read-back
  logic [rtc_pkg::GPIO_W-1:0] rbk_b_bus; // four-channel variant bus
  // ----------------------------------------------------------------
  // serial command handshake
  // ----------------------------------------------------------------
  logic spi_wr_en; // 1 write, 0 read
  logic [rtc_pkg::ADDR_W-1:0] spi_addr; // register address
  logic [rtc_pkg::DATA_W-1:0] spi_wdat; // write data
  logic [rtc_pkg::SEL_W-1:0] spi_sel; // target select
  logic spi_start; // one-cycle launch pulse
  logic spi_done; // low while busy
  logic [rtc_pkg::DATA_W-1:0] spi_rdat; // read data

  // top-level side
  modport dev (
    input ovr_mask, flt_mask, drv_val,
    output rbk_bus, rbk_b_bus,
    input spi_wr_en, spi_addr, spi_wdat, spi_sel, spi_start,
    output spi_done, spi_rdat
  );
  // user application side
  modport usr (
    output ovr_mask, flt_mask, drv_val,
    input rbk_bus, rbk_b_bus,
    output spi_wr_en, spi_addr, spi_wdat, spi_sel, spi_start,
    input spi_done, spi_rdat
  );
endinterface : rtc_link_if
`default_nettype wire

// ### logic/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int GPIO_W = 8; // transceiver digital bus bits
  localparam int ADDR_W = 16; // serial register address
  localparam int DATA_W = 8; // serial register data
  localparam int SEL_W = 2; // target select field
  localparam int CS_N = 4; // chip selects, indexed by select code; code 2 drives none low
  localparam int FRAME_W = 1 + ADDR_W + DATA_W; // dir bit, addr, data
  localparam int BIT_W = 5; // bit counter width
  localparam int DIV_W = 4; // serial clock divider width

  // ----------------------------------------------------------------
  // target select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_RFIC = 2'h0; // transceiver
  localparam logic [1:0] SEL_CLK = 2'h1; // clock / link chip
  localparam logic [1:0] SEL_NONE = 2'h2; // unused, no select
  localparam logic [1:0] SEL_REFDAC = 2'h3; // reference dac

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100; // mclk period
  localparam int SCK_HALF_NS = 200; // least serial clock half period
  localparam int SCK_HALF_CYC_I = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SCK_HALF_CYC =
    (SCK_HALF_CYC_I < 1) ? 4'h1 : SCK_HALF_CYC_I[3:0];

  // ----------------------------------------------------------------
  // controller register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OVR = 8'h00; // override mask
  localparam logic [7:0] OFS_FLT = 8'h04; // float mask
  localparam logic [7:0] OFS_DRV = 8'h08; // drive value
  localparam logic [7:0] OFS_RBK = 8'h0C; // read-back (ro)
  localparam logic [7:0] OFS_RBK_B = 8'h10; // four-channel bus (ro)
  localparam logic [7:0] OFS_CMD = 8'h14; // command, write launches
  localparam logic [7:0] OFS_WDAT = 8'h18; // serial write data
  localparam logic [7:0] OFS_STAT = 8'h1C; // status (ro)

  // command register fields
  localparam int CMD_WR_BIT = 0; // 1 write, 0 read
  localparam int CMD_SEL_LSB = 1; // select [2:1]
  localparam int CMD_ADDR_LSB = 16; // address [31:16]
  // status register fields
  localparam int ST_DONE_BIT = 0; // done level
  localparam int ST_BUSY_BIT = 1; // command outstanding
  localparam int ST_RDAT_LSB = 8; // read data [15:8]
endpackage : rtc_pkg
`default_nettype wire

// ### logic/rtc_spi_engine.sv
`timescale 1ns/1ps
`default_nettype none
// serial shift engine: one frame of dir, address and data
module rtc_spi_engine (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // command
  input wire logic start,
  input wire logic wr_en,
  input wire logic [rtc_pkg::SEL_W-1:0] sel,
  input wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input wire logic [rtc_pkg::DATA_W-1:0] wdat,
  output logic done,
  output logic [rtc_pkg::DATA_W-1:0] rdat,
  // serial pins, miso already synchronised
  input wire logic miso,
  output logic sclk,
  output logic [rtc_pkg::CS_N-1:0] cs_n,
  output logic mosi
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, // waiting for start
    ST_SHIFT = 2'h1, // clocking bits
    ST_END = 2'h2 // release select, report
  } rtc_eng_st_t;

  typedef struct packed {
    rtc_eng_st_t st;
    logic [rtc_pkg::DIV_W-1:0] div; // half period counter
    logic [rtc_pkg::BIT_W-1:0] bits; // bits clocked so far
    logic [rtc_pkg::FRAME_W-1:0] shf; // shift register
    logic is_wr; // frame is a write
    logic done;
    logic [rtc_pkg::DATA_W-1:0] rdat;
    logic sclk;
    logic [rtc_pkg::CS_N-1:0] cs_n;
    logic mosi;
  } rtc_eng_t;

  rtc_eng_t s_reg;
  rtc_eng_t s_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      ST_IDLE: begin
        if (start) begin
          // read flag goes first on the wire
          s_next.shf = {~wr_en, addr, wdat};
          s_next.mosi = ~wr_en;
          s_next.is_wr = wr_en;
          s_next.done = 1'b0;
          s_next.div = 4'h0;
          s_next.bits = 5'h00;
          // unused code selects nothing but still runs
          if (sel != rtc_pkg::SEL_NONE) begin
            s_next.cs_n[sel] = 1'b0;
          end
          s_next.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (s_reg.div == rtc_pkg::SCK_HALF_CYC - 4'h1) begin
          s_next.div = 4'h0;
          s_next.sclk = ~s_reg.sclk;
          if (!s_reg.sclk) begin
            // rising edge: sample miso
            s_next.shf = {s_reg.shf[rtc_pkg::FRAME_W-2:0], miso};
          end else if (s_reg.bits == 5'(rtc_pkg::FRAME_W - 1)) begin
            s_next.st = ST_END;
          end else begin
            // falling edge: present next bit
            s_next.bits = s_reg.bits + 5'h01;
            s_next.mosi = s_reg.shf[rtc_pkg::FRAME_W-1];
          end
        end else begin
          s_next.div = s_reg.div + 4'h1;
        end
      end
      ST_END: begin
        s_next.cs_n = '1;
        s_next.mosi = 1'b0;
        if (!s_reg.is_wr) begin
          s_next.rdat = s_reg.shf[rtc_pkg::DATA_W-1:0];
        end
        s_next.done = 1'b1;
        s_next.st = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: ST_IDLE, done: 1'b1, cs_n: '1, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign rdat = s_reg.rdat;
  assign sclk = s_reg.sclk;
  assign cs_n = s_reg.cs_n;
  assign mosi = s_reg.mosi;
endmodule : rtc_spi_engine
`default_nettype wire

// ### logic/rtc_top_end.sv
// Notes on behaviour
// - both ports run on the one host clock
// - override mask bit hands pin to user
// - float bit tristates pin, only when overridden
// - read-back shows true pin level when not driven
// - overridden, not floated: drive user value
// - four-channel bus mirrors pin levels, no override
// - user overrides only bits it needs
// - user sets flag 0 read, 1 write
// - user gives address and write data
// - select 0 rfic, 1 clock, 3 dac
// - start is one host-clock pulse
// - done drops after start, rises when finished
// - read data shown after read completes
`timescale 1ns/1ps
`default_nettype none
// top-level end: owns the gpio pins and the serial master
module rtc_top_end (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // link to the user application
  rtc_link_if.dev lk,
  // default top-level control of the gpio bus
  input wire logic [rtc_pkg::GPIO_W-1:0] top_gpio_out,
  input wire logic [rtc_pkg::GPIO_W-1:0] top_gpio_oe,
  // transceiver gpio pins
  input wire logic [rtc_pkg::GPIO_W-1:0] gpio_pin_in,
  output logic [rtc_pkg::GPIO_W-1:0] gpio_pin_out,
  output logic [rtc_pkg::GPIO_W-1:0] gpio_pin_oe,
  // serial bus pins
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic [rtc_pkg::CS_N-1:0] spi_cs_n,
  output logic spi_mosi
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [rtc_pkg::GPIO_W-1:0] pin_s1; // first sync stage
    logic [rtc_pkg::GPIO_W-1:0] pin_s2; // second sync stage
    logic miso_s1; // first sync stage
    logic miso_s2; // second sync stage
    logic [rtc_pkg::GPIO_W-1:0] pad_out; // pin drive value
    logic [rtc_pkg::GPIO_W-1:0] pad_oe; // pin enable
    logic [rtc_pkg::GPIO_W-1:0] rbk; // read-back bus
    logic [rtc_pkg::GPIO_W-1:0] rbk_b; // four-channel bus
  } rtc_top_t;

  rtc_top_t s_reg;
  rtc_top_t s_next;

  // per-bit pin drive choice
  logic [rtc_pkg::GPIO_W-1:0] mux_out;
  logic [rtc_pkg::GPIO_W-1:0] mux_oe;

  // ----------------------------------------------------------------
  // per-bit override mux
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < rtc_pkg::GPIO_W; gi = gi + 1) begin : g_bit
      always_comb begin
        if (lk.ovr_mask[gi]) begin
          // user owns the bit
          mux_out[gi] = lk.drv_val[gi];
          mux_oe[gi] = ~lk.flt_mask[gi];
        end else begin
          // float mask is ignored here
          mux_out[gi] = top_gpio_out[gi];
          mux_oe[gi] = top_gpio_oe[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // pins come from outside the clock domain
    s_next.pin_s1 = gpio_pin_in;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.miso_s1 = spi_miso;
    s_next.miso_s2 = s_reg.miso_s1;
    // registered drive, one cycle behind the masks
    s_next.pad_out = mux_out;
    s_next.pad_oe = mux_oe;
    // true level of each pin, whoever drives it
    s_next.rbk = s_reg.pin_s2;
    // same levels on the four-channel bus
    s_next.rbk_b = s_reg.pin_s2;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // serial master
  // ----------------------------------------------------------------
  // start is taken as a single-cycle pulse
  rtc_spi_engine u_eng (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .start(lk.spi_start),
    .wr_en(lk.spi_wr_en),
    .sel(lk.spi_sel),
    .addr(lk.spi_addr),
    .wdat(lk.spi_wdat),
    .done(lk.spi_done),
    .rdat(lk.spi_rdat),
    .miso(s_reg.miso_s2),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign gpio_pin_out = s_reg.pad_out;
  assign gpio_pin_oe = s_reg.pad_oe;
  assign lk.rbk_bus = s_reg.rbk;
  assign lk.rbk_b_bus = s_reg.rbk_b;
endmodule : rtc_top_end
`default_nettype wire

// ### logic/rtc_user_end.sv
`timescale 1ns/1ps
`default_nettype none
// user application end: registers drive the link
module rtc_user_end (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // link to the top-level logic
  rtc_link_if.usr lk,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CS_IDLE = 2'h0, // nothing outstanding
    CS_WLOW = 2'h1, // start sent, done not yet low
    CS_WHIGH = 2'h2 // done low, waiting for return
  } rtc_cmd_st_t;

  typedef struct packed {
    rtc_cmd_st_t st;
    logic [rtc_pkg::GPIO_W-1:0] ovr;
    logic [rtc_pkg::GPIO_W-1:0] flt;
    logic [rtc_pkg::GPIO_W-1:0] drv;
    logic wr_en;
    logic [rtc_pkg::SEL_W-1:0] sel;
    logic [rtc_pkg::ADDR_W-1:0] addr;
    logic [rtc_pkg::DATA_W-1:0] wdat;
    logic start;
    logic [31:0] rdata;
  } rtc_usr_t;

  rtc_usr_t s_reg;
  rtc_usr_t s_next;
  logic busy; // a command is outstanding

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    busy = (s_reg.st != CS_IDLE) || !lk.spi_done;
    s_next.start = 1'b0;
    s_next.rdata = 32'h0000_0000;
    // handshake tracking
    case (s_reg.st)
      CS_WLOW: begin
        if (!lk.spi_done) s_next.st = CS_WHIGH;
      end
      CS_WHIGH: begin
        if (lk.spi_done) s_next.st = CS_IDLE;
      end
      default: begin
        s_next.st = CS_IDLE;
      end
    endcase
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        rtc_pkg::OFS_OVR: s_next.ovr = reg_wdata[rtc_pkg::GPIO_W-1:0];
        rtc_pkg::OFS_FLT: s_next.flt = reg_wdata[rtc_pkg::GPIO_W-1:0];
        rtc_pkg::OFS_DRV: s_next.drv = reg_wdata[rtc_pkg::GPIO_W-1:0];
        rtc_pkg::OFS_WDAT: begin
          // held while outstanding
          if (!busy) s_next.wdat = reg_wdata[rtc_pkg::DATA_W-1:0];
        end
        rtc_pkg::OFS_CMD: begin
          // one command at a time
          if (!busy) begin
            s_next.wr_en = reg_wdata[rtc_pkg::CMD_WR_BIT];
            s_next.sel = reg_wdata[rtc_pkg::CMD_SEL_LSB +: 2];
            s_next.addr = reg_wdata[rtc_pkg::CMD_ADDR_LSB +: 16];
            s_next.start = 1'b1;
            s_next.st = CS_WLOW;
          end
        end
        default: begin
        end
      endcase
    end
    // register reads, data in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        rtc_pkg::OFS_OVR: s_next.rdata[7:0] = s_reg.ovr;
        rtc_pkg::OFS_FLT: s_next.rdata[7:0] = s_reg.flt;
        rtc_pkg::OFS_DRV: s_next.rdata[7:0] = s_reg.drv;
        rtc_pkg::OFS_RBK: s_next.rdata[7:0] = lk.rbk_bus;
        rtc_pkg::OFS_RBK_B: s_next.rdata[7:0] = lk.rbk_b_bus;
        rtc_pkg::OFS_WDAT: s_next.rdata[7:0] = s_reg.wdat;
        rtc_pkg::OFS_CMD: s_next.rdata = {s_reg.addr, 13'h0000,
          s_reg.sel, s_reg.wr_en};
        rtc_pkg::OFS_STAT: begin
          s_next.rdata[rtc_pkg::ST_DONE_BIT] = lk.spi_done;
          s_next.rdata[rtc_pkg::ST_BUSY_BIT] = busy;
          s_next.rdata[rtc_pkg::ST_RDAT_LSB +: 8] = lk.spi_rdat;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: CS_IDLE, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // outputs, all from flops
  assign lk.ovr_mask = s_reg.ovr;
  assign lk.flt_mask = s_reg.flt;
  assign lk.drv_val = s_reg.drv;
  assign lk.spi_wr_en = s_reg.wr_en;
  assign lk.spi_sel = s_reg.sel;
  assign lk.spi_addr = s_reg.addr;
  assign lk.spi_wdat = s_reg.wdat;
  assign lk.spi_start = s_reg.start;
  assign reg_rdata = s_reg.rdata;
endmodule : rtc_user_end
`default_nettype wire

// ### verification/rf_transceiver_ctrl_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
// bench for both ends joined by the link
module rf_transceiver_ctrl_port_bench;
  // gpio case: inputs, then expected pin enable and masked drive
  typedef struct packed {
    logic [7:0] ovr, flt, drv, tout, toe, pin, oe, out;
  } rtc_row_t;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk, resetn, ce, reg_wr, reg_rd, miso, sclk, mosi;
  logic [7:0] reg_addr, top_out, top_oe, ext_pin, pin_in, pin_out, pin_oe;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] cs_n;
  int error_cnt, check_count;
  rtc_row_t rows [5];
  // wire level: our drive where enabled, transceiver elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pin);
  rtc_link_if lk ();
  rtc_user_end rtc_user_end_inst (.mclk(mclk), .resetn(resetn),
    .ce(ce), .lk(lk.usr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rtc_top_end rtc_top_end_inst (.mclk(mclk), .resetn(resetn),
    .ce(ce), .lk(lk.dev), .top_gpio_out(top_out),
    .top_gpio_oe(top_oe), .gpio_pin_in(pin_in), .gpio_pin_out(pin_out),
    .gpio_pin_oe(pin_oe), .spi_miso(miso), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi));
  rtc_link_props rtc_link_props_inst (.mclk(mclk), .resetn(resetn),
    .rbk_bus(lk.rbk_bus), .rbk_b_bus(lk.rbk_b_bus),
    .spi_wr_en(lk.spi_wr_en), .spi_addr(lk.spi_addr),
    .spi_wdat(lk.spi_wdat), .spi_sel(lk.spi_sel),
    .spi_start(lk.spi_start), .spi_done(lk.spi_done),
    .spi_rdat(lk.spi_rdat));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // compare and count
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // verdict and end of run
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // one-cycle register write
  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // one-cycle register read, data taken in the following cycle
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  // bounded wait for the done level
  task automatic wait_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      #1;
      if (lk.spi_done === 1'b1) break;
    end
    if (i == 300) begin
      error_cnt++;
      test_done();
    end
  endtask : wait_idle
  // launch a command and capture the serial frame on sclk rises
  task automatic run_cmd(logic wr, logic [1:0] sel, logic [15:0] a,
                         logic [7:0] d);
    logic [24:0] frame;
    logic [3:0] cs_seen, cs_exp;
    logic prev;
    int i;
    frame = '0;
    cs_seen = 4'hF;
    prev = 1'b0;
    cs_exp = (sel == 2'h2) ? 4'hF : ~(4'h1 << sel);
    reg_write(rtc_pkg::OFS_WDAT, {24'h0, d});
    reg_write(rtc_pkg::OFS_CMD, {a, 13'h0, sel, wr});
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      #1;
      if (sclk === 1'b1 && !prev) begin
        frame = {frame[23:0], mosi};
        cs_seen = cs_n;
      end
      prev = sclk;
      if (i > 3 && lk.spi_done === 1'b1) break;
    end
    if (i == 300) begin
      error_cnt++;
      test_done();
    end
    chk("cs_n", cs_exp, cs_seen);
    chk("dir", !wr, frame[24]);
    chk("addr", a, frame[23:8]);
    if (wr) chk("wdat", d, frame[7:0]);
  endtask : run_cmd
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    logic [31:0] d;
    logic [7:0] e;
    int k, s, lows;
    resetn = 1'b0;
    {reg_wr, reg_rd, miso} = 3'h0;
    ce = 1'b1;
    {reg_addr, top_out, top_oe, ext_pin} = 32'h0;
    reg_wdata = 32'h0;
    error_cnt = 0;
    check_count = 0;
    rows[0] = '{8'h00, 8'hFF, 8'hAA, 8'h5A, 8'hF0, 8'h3C, 8'hF0, 8'h50};
    rows[1] = '{8'hFF, 8'h00, 8'hA5, 8'h00, 8'h00, 8'hC3, 8'hFF, 8'hA5};
    rows[2] = '{8'hFF, 8'hFF, 8'h5A, 8'hFF, 8'hFF, 8'h96, 8'h00, 8'h00};
    rows[3] = '{8'h0F, 8'h33, 8'hFF, 8'h0F, 8'hC3, 8'h69, 8'hCC, 8'h0C};
    rows[4] = '{8'hF0, 8'h0F, 8'h30, 8'h0A, 8'h05, 8'h12, 8'hF5, 8'h30};
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    // reset state and an unmapped place
    reg_read(rtc_pkg::OFS_STAT, d);
    chk("stat_rst", 32'h1, d & 32'h3);
    reg_read(8'h40, d);
    chk("unmapped", 32'h0, d);
    // gpio table
    foreach (rows[k]) begin
      reg_write(rtc_pkg::OFS_OVR, {24'h0, rows[k].ovr});
      reg_write(rtc_pkg::OFS_FLT, {24'h0, rows[k].flt});
      reg_write(rtc_pkg::OFS_DRV, {24'h0, rows[k].drv});
      top_out <= rows[k].tout;
      top_oe <= rows[k].toe;
      ext_pin <= rows[k].pin;
      repeat (6) @(posedge mclk);
      #1;
      e = (rows[k].oe & rows[k].out) | (~rows[k].oe & rows[k].pin);
      chk("pin_oe", rows[k].oe, pin_oe);
      chk("pin_out", rows[k].out, pin_out & pin_oe);
      reg_read(rtc_pkg::OFS_RBK, d);
      chk("rbk", e, d);
      reg_read(rtc_pkg::OFS_RBK_B, d);
      chk("rbk_b", e, d);
    end
    // float mask and drive registers read back as last written
    reg_read(rtc_pkg::OFS_FLT, d);
    chk("flt_rb", 32'h0F, d);
    reg_read(rtc_pkg::OFS_DRV, d);
    chk("drv_rb", 32'h30, d);
    // writes to every select code, then reads with both miso levels
    for (s = 0; s < 4; s++) begin
      run_cmd(1'b1, s[1:0], 16'hF00F ^ {8'h0, 8'(s)}, 8'h81 + 8'(s));
    end
    miso <= 1'b1;
    run_cmd(1'b0, 2'h0, 16'h0123, 8'h00);
    reg_read(rtc_pkg::OFS_STAT, d);
    chk("rdat_ff", 32'hFF, d[15:8]);
    miso <= 1'b0;
    run_cmd(1'b0, 2'h3, 16'hFFFF, 8'h00);
    chk("rdat_00", 32'h0, lk.spi_rdat);
    // command written while busy is refused
    reg_write(rtc_pkg::OFS_CMD, {16'h1111, 13'h0, 2'h1, 1'b1});
    repeat (4) @(posedge mclk);
    #1;
    chk("done_low", 32'h0, lk.spi_done);
    reg_read(rtc_pkg::OFS_STAT, d);
    chk("stat_busy", 32'h2, d & 32'h3);
    reg_write(rtc_pkg::OFS_CMD, {16'h2222, 13'h0, 2'h0, 1'b1});
    reg_write(rtc_pkg::OFS_WDAT, 32'h5C);
    wait_idle();
    chk("addr_kept", 32'h1111, lk.spi_addr);
    reg_read(rtc_pkg::OFS_CMD, d);
    chk("cmd_kept", {16'h1111, 13'h0, 2'h1, 1'b1}, d);
    reg_read(rtc_pkg::OFS_WDAT, d);
    chk("wdat_kept", 32'h0, d);
    lows = 0;
    repeat (20) begin
      @(posedge mclk);
      #1;
      if (lk.spi_done !== 1'b1) lows++;
    end
    chk("no_restart", 32'h0, lows);
    // reset in mid-transfer
    reg_write(rtc_pkg::OFS_CMD, {16'h3333, 13'h0, 2'h0, 1'b1});
    repeat (10) @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rst_done", 32'h1, lk.spi_done);
    chk("rst_cs", 32'hF, cs_n);
    chk("rst_oe", 32'h0, pin_oe);
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    reg_read(rtc_pkg::OFS_OVR, d);
    chk("rst_ovr", 32'h0, d);
    // clock enable low freezes every register
    @(posedge mclk);
    ce <= 1'b0;
    reg_write(rtc_pkg::OFS_OVR, 32'hFF);
    ce <= 1'b1;
    reg_read(rtc_pkg::OFS_OVR, d);
    chk("ce_hold", 32'h0, d);
    test_done();
  end
endmodule : rf_transceiver_ctrl_port_bench
`default_nettype wire

// ### verification/rtc_link_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// checker on the link between user end and top-level end
// ----------------------------------------------------------------
module rtc_link_props (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // read-back buses
  input wire logic [rtc_pkg::GPIO_W-1:0] rbk_bus,
  input wire logic [rtc_pkg::GPIO_W-1:0] rbk_b_bus,
  // command handshake
  input wire logic spi_wr_en,
  input wire logic [rtc_pkg::ADDR_W-1:0] spi_addr,
  input wire logic [rtc_pkg::DATA_W-1:0] spi_wdat,
  input wire logic [rtc_pkg::SEL_W-1:0] spi_sel,
  input wire logic spi_start,
  input wire logic spi_done,
  input wire logic [rtc_pkg::DATA_W-1:0] spi_rdat
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // command fields packed for hold checks
  logic [26:0] fields;
  assign fields = {spi_wr_en, spi_addr, spi_wdat, spi_sel};

  property p_start_pulse;
    spi_start |=> !spi_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_done_falls;
    spi_start && spi_done |=> !spi_done;
  endproperty
  a_done_falls: assert property (p_done_falls)
    else $error("done did not drop after start");
  property p_done_cause;
    $fell(spi_done) |-> $past(spi_start);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done dropped without start");
  property p_done_min;
    $fell(spi_done) |-> !spi_done [*8];
  endproperty
  a_done_min: assert property (p_done_min)
    else $error("done returned too early");
  property p_done_max;
    $fell(spi_done) |-> ##[90:110] $rose(spi_done);
  endproperty
  a_done_max: assert property (p_done_max)
    else $error("done did not return in time");
  property p_no_start_busy;
    !spi_done |-> !spi_start;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy)
    else $error("start while busy");
  property p_fields_hold;
    !spi_done |-> $stable(fields);
  endproperty
  a_fields_hold: assert property (p_fields_hold)
    else $error("command fields moved while busy");
  property p_rdat_hold;
    !$rose(spi_done) |-> $stable(spi_rdat);
  endproperty
  a_rdat_hold: assert property (p_rdat_hold)
    else $error("read data moved outside completion");
  property p_rbk_same;
    rbk_b_bus == rbk_bus;
  endproperty
  a_rbk_same: assert property (p_rbk_same)
    else $error("second read-back bus differs");
endmodule : rtc_link_props
`default_nettype wire
